// ### common/spcr_pkg.sv
package spcr_pkg;
   localparam int ADDR_W = 13;
   localparam logic [12:0] ADDR_SETUP = 13'h0000;
   localparam logic [12:0] ADDR_RDBK = 13'h0004;
   localparam logic [12:0] ADDR_VER_LO = 13'h0005;
   localparam logic [12:0] ADDR_VER_HI = 13'h0006;
   localparam int SETUP_FOUR_WIRE = 7;
   localparam int SETUP_LSB_FIRST = 6;
   localparam int SETUP_SOFT_RST = 5;
   localparam int RDBK_SEL = 0;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] RDBK_RESET = 8'h00;
   localparam logic [7:0] VER_LO_RESET = 8'h00;
   localparam logic [7:0] VER_HI_RESET = 8'h00;
   localparam int INSTR_RW_POS = 15;
   localparam logic [3:0] INSTR_LAST = 4'hf;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_INSTR = 3'h2,
      ST_DATA = 3'h4
   } spcr_state_t;
endpackage

// ### hdl/spcr_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for slow pin levels; only the second stage is visible.
module spcr_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   if (WIDTH < 1) begin : g_chk
      $error("spcr_sync: WIDTH must be at least 1.");
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;
endmodule

// ### hdl/spcr_serial_port_config_regs.sv
`timescale 1ns/1ps
// How it works
// [RULE1] Four-wire bit clear (default): reads go out on SDIO, SDO stays undriven.
// [RULE2] Four-wire bit set: reads go out on SDO, writes come in on SDIO only.
// [RULE3] Bit-order bit clear (default): MSB first, address decrements per byte.
// [RULE4] Bit-order bit set: LSB first, address increments per byte.
// [RULE5] In I2C mode bits 7 and 6 of the setup byte are ignored and reserved.
// [RULE6] Writing 1 to bit 5 restores register defaults; the bit clears itself.
// [RULE7] Host writes setup bits 3..0 as the mirror of bits 7..4.
// [RULE8] Readback select clear (default): buffered addresses return active values.
// [RULE9] Readback select set: buffered addresses return pending buffered values.
// [RULE10] A 16-bit version tag sits at 0x005 (low) and 0x006 (high), default 0.
// [RULE11] The version tag is plain storage with no effect on other behaviour.
// [RULE12] Reserved bits read as zero and ignore writes.
module spcr_serial_port_config_regs (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic spi_csb_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   input wire logic i2c_mode_i,
   output logic [12:0] ext_addr_o,
   output logic [7:0] ext_wdata_o,
   output logic ext_we_o,
   input wire logic [7:0] ext_active_rdata_i,
   input wire logic [7:0] ext_buffer_rdata_i,
   output logic four_wire_select_o,
   output logic lsb_first_o,
   output logic readback_buffer_o,
   output logic soft_reset_o,
   output logic [15:0] user_version_tag_o
);
   logic [3:0] pins_s;
   logic sclk_d_r;
   logic sclk_rise;
   logic sclk_fall;
   logic csb_n_s;
   logic sclk_s;
   logic sdio_s;
   logic i2c_s;
   spcr_pkg::spcr_state_t state_r;
   logic [3:0] cnt_r;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic rw_r;
   logic [12:0] addr_r;
   logic frame_4w_r;
   logic frame_lsb_r;
   logic [7:0] tx_r;
   logic out_bit_r;
   logic byte_done;
   logic wr_en;
   logic [7:0] wr_byte;
   logic int_hit;
   logic [7:0] rd_data;
   logic [7:0] setup_rd;
   logic four_wire_r;
   logic lsb_first_r;
   logic rdbk_sel_r;
   logic [7:0] ver_lo_r;
   logic [7:0] ver_hi_r;
   logic soft_rst_r;
   logic ext_we_r;
   logic [12:0] ext_addr_r;
   logic [7:0] ext_wdata_r;

   function automatic logic [7:0] byte_of(input logic [15:0] sh, input logic lsb);
      byte_of = lsb ? sh[15:8] : sh[7:0];
   endfunction

   function automatic logic [12:0] addr_step(input logic [12:0] a, input logic lsb);
      addr_step = lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
   endfunction

   function automatic logic is_internal(input logic [12:0] a);
      is_internal = (a == spcr_pkg::ADDR_SETUP) || (a == spcr_pkg::ADDR_RDBK) ||
                    (a == spcr_pkg::ADDR_VER_LO) || (a == spcr_pkg::ADDR_VER_HI);
   endfunction

   // Chip select resets to its idle level, so leaving reset can never open a frame.
   spcr_sync #(
      .WIDTH(4),
      .RESET_VAL(4'h4)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .async_i({i2c_mode_i, spi_csb_n_i, spi_sclk_i, spi_sdio_i}),
      .sync_o(pins_s)
   );

   assign i2c_s = pins_s[3];
   assign csb_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign sdio_s = pins_s[0];

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;

   // Write data is taken from SDIO only, in both wiring modes.
   always_comb begin
      if (frame_lsb_r) begin
         shift_nxt = {sdio_s, shift_r[15:1]}; // [RULE4]
      end else begin
         shift_nxt = {shift_r[14:0], sdio_s}; // [RULE3]
      end
   end

   assign byte_done = (state_r == spcr_pkg::ST_DATA) && sclk_rise && (cnt_r == spcr_pkg::BYTE_LAST);
   assign wr_en = byte_done && !rw_r;
   assign wr_byte = byte_of(shift_nxt, frame_lsb_r);

   // Wiring and bit order are frozen at frame start so a write to the setup
   // byte cannot change the pin mapping halfway through its own frame.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || csb_n_s) begin
         state_r <= spcr_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 16'h0000;
         rw_r <= 1'b0;
         addr_r <= spcr_pkg::ADDR_SETUP;
         frame_4w_r <= 1'b0;
         frame_lsb_r <= 1'b0;
      end else begin
         case (state_r)
            spcr_pkg::ST_IDLE: begin
               state_r <= spcr_pkg::ST_INSTR;
               cnt_r <= 4'h0;
               frame_4w_r <= four_wire_r & ~i2c_s;
               frame_lsb_r <= lsb_first_r & ~i2c_s;
            end
            spcr_pkg::ST_INSTR: begin
               if (sclk_rise) begin
                  shift_r <= shift_nxt;
                  cnt_r <= 4'(cnt_r + 4'h1);
                  if (cnt_r == spcr_pkg::INSTR_LAST) begin
                     rw_r <= shift_nxt[spcr_pkg::INSTR_RW_POS];
                     addr_r <= shift_nxt[12:0];
                     cnt_r <= 4'h0;
                     state_r <= spcr_pkg::ST_DATA;
                  end
               end
            end
            spcr_pkg::ST_DATA: begin
               if (sclk_rise) begin
                  shift_r <= shift_nxt;
                  cnt_r <= 4'(cnt_r + 4'h1);
                  if (cnt_r == spcr_pkg::BYTE_LAST) begin
                     cnt_r <= 4'h0;
                     addr_r <= addr_step(addr_r, frame_lsb_r); // [RULE3] [RULE4]
                  end
               end
            end
            default: begin
               state_r <= spcr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Mirror nibble is rebuilt from the stored bits, so readback is order-proof.
   always_comb begin
      setup_rd = 8'h00; // [RULE12]
      if (!i2c_s) begin
         setup_rd[spcr_pkg::SETUP_FOUR_WIRE] = four_wire_r;
         setup_rd[spcr_pkg::SETUP_LSB_FIRST] = lsb_first_r;
         setup_rd[0] = four_wire_r; // [RULE7]
         setup_rd[1] = lsb_first_r; // [RULE7]
      end
   end

   assign int_hit = is_internal(addr_r);

   always_comb begin
      case (addr_r)
         spcr_pkg::ADDR_SETUP: rd_data = setup_rd;
         spcr_pkg::ADDR_RDBK: rd_data = {7'h00, rdbk_sel_r}; // [RULE12]
         spcr_pkg::ADDR_VER_LO: rd_data = ver_lo_r;
         spcr_pkg::ADDR_VER_HI: rd_data = ver_hi_r;
         default: rd_data = rdbk_sel_r ? ext_buffer_rdata_i : ext_active_rdata_i; // [RULE8] [RULE9]
      endcase
   end

   // The outgoing byte is refreshed only between bytes so it cannot tear.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         tx_r <= 8'h00;
         out_bit_r <= 1'b0;
      end else begin
         if (cnt_r == 4'h0) begin
            tx_r <= rd_data;
         end
         if (sclk_fall && state_r == spcr_pkg::ST_DATA) begin
            out_bit_r <= frame_lsb_r ? tx_r[cnt_r[2:0]] : tx_r[3'(7 - cnt_r[2:0])];
         end
      end
   end

   assign spi_sdio_o = out_bit_r;
   assign spi_sdo_o = out_bit_r;
   assign spi_sdio_oe_o = (state_r == spcr_pkg::ST_DATA) && rw_r && !frame_4w_r; // [RULE1]
   assign spi_sdo_oe_o = (state_r == spcr_pkg::ST_DATA) && rw_r && frame_4w_r; // [RULE2]

   // Soft reset takes one cycle to land; the request bit is never stored.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_en && (addr_r == spcr_pkg::ADDR_SETUP) && wr_byte[spcr_pkg::SETUP_SOFT_RST]; // [RULE6]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || soft_rst_r) begin
         four_wire_r <= spcr_pkg::SETUP_RESET[spcr_pkg::SETUP_FOUR_WIRE]; // [RULE6]
         lsb_first_r <= spcr_pkg::SETUP_RESET[spcr_pkg::SETUP_LSB_FIRST];
         rdbk_sel_r <= spcr_pkg::RDBK_RESET[spcr_pkg::RDBK_SEL];
         ver_lo_r <= spcr_pkg::VER_LO_RESET; // [RULE10]
         ver_hi_r <= spcr_pkg::VER_HI_RESET; // [RULE10]
      end else if (wr_en) begin
         case (addr_r)
            spcr_pkg::ADDR_SETUP: begin
               if (!i2c_s) begin
                  four_wire_r <= wr_byte[spcr_pkg::SETUP_FOUR_WIRE]; // [RULE5]
                  lsb_first_r <= wr_byte[spcr_pkg::SETUP_LSB_FIRST];
               end
            end
            spcr_pkg::ADDR_RDBK: rdbk_sel_r <= wr_byte[spcr_pkg::RDBK_SEL];
            spcr_pkg::ADDR_VER_LO: ver_lo_r <= wr_byte; // [RULE11]
            spcr_pkg::ADDR_VER_HI: ver_hi_r <= wr_byte; // [RULE11]
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ext_we_r <= 1'b0;
         ext_addr_r <= 13'h0000;
         ext_wdata_r <= 8'h00;
      end else begin
         ext_we_r <= wr_en && !int_hit;
         if (wr_en && !int_hit) begin
            ext_addr_r <= addr_r;
            ext_wdata_r <= wr_byte;
         end
      end
   end

   assign ext_we_o = ext_we_r;
   assign ext_addr_o = ext_we_r ? ext_addr_r : addr_r;
   assign ext_wdata_o = ext_wdata_r;
   assign four_wire_select_o = four_wire_r & ~i2c_s; // [RULE5]
   assign lsb_first_o = lsb_first_r & ~i2c_s; // [RULE5]
   assign readback_buffer_o = rdbk_sel_r;
   assign soft_reset_o = soft_rst_r;
   assign user_version_tag_o = {ver_hi_r, ver_lo_r};

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   a_three_wire_sdo: assert property (!frame_4w_r |-> !spi_sdo_oe_o) // [RULE1]
      else $error("SDO driven in three-wire mode.");
   a_four_wire_pins: assert property (spi_sdo_oe_o |-> frame_4w_r && !spi_sdio_oe_o) // [RULE2]
      else $error("SDIO driven while reading on SDO.");
   a_msb_addr_dec: assert property (byte_done && !frame_lsb_r && !csb_n_s |=> addr_r == 13'($past(addr_r) - 13'h0001)) // [RULE3]
      else $error("Address did not decrement in MSB-first mode.");
   a_lsb_addr_inc: assert property (byte_done && frame_lsb_r && !csb_n_s |=> addr_r == 13'($past(addr_r) + 13'h0001)) // [RULE4]
      else $error("Address did not increment in LSB-first mode.");
   a_i2c_bits_idle: assert property (i2c_s && wr_en && addr_r == spcr_pkg::ADDR_SETUP |=> $stable(four_wire_r) && $stable(lsb_first_r)) // [RULE5]
      else $error("Setup bits 7:6 changed in I2C mode.");
   a_soft_reset_clr: assert property (soft_rst_r |=> !soft_rst_r && user_version_tag_o == 16'h0000 && !readback_buffer_o) // [RULE6]
      else $error("Soft reset did not restore defaults or did not self-clear.");
   a_readback_active: assert property (!int_hit && !rdbk_sel_r |-> rd_data == ext_active_rdata_i) // [RULE8]
      else $error("Readback did not select active value.");
   a_readback_buffer: assert property (!int_hit && rdbk_sel_r |-> rd_data == ext_buffer_rdata_i) // [RULE9]
      else $error("Readback did not select buffered value.");
   a_ver_reset_zero: assert property (@(posedge sys_clk_i) disable iff (1'b0) reset_i |=> user_version_tag_o == 16'h0000) // [RULE10]
      else $error("Version tag not zero after reset.");
   a_ver_hold: assert property (!wr_en && !soft_rst_r |=> $stable(user_version_tag_o)) // [RULE11]
      else $error("Version tag changed without a write.");
   a_rsvd_zero: assert property (addr_r == spcr_pkg::ADDR_RDBK |-> rd_data[7:1] == 7'h00) // [RULE12]
      else $error("Reserved bits of readback select read nonzero.");
   a_setup_rsvd: assert property (addr_r == spcr_pkg::ADDR_SETUP |-> rd_data[5:2] == 4'h0) // [RULE12]
      else $error("Reserved bits of setup byte read nonzero.");
   a_i2c_read_zero: assert property (i2c_s && addr_r == spcr_pkg::ADDR_SETUP |-> rd_data[7:6] == 2'b00) // [RULE5]
      else $error("Setup bits 7:6 read nonzero in I2C mode.");
   // Pin drive is tied to the data phase, so a stray edge cannot fight the host.
   a_idle_no_drive: assert property (state_r != spcr_pkg::ST_DATA |-> !spi_sdio_oe_o && !spi_sdo_oe_o) // [RULE1]
      else $error("Data pin driven outside a data phase.");
   a_ext_no_internal: assert property (ext_we_o |-> !is_internal(ext_addr_o)) // [RULE11]
      else $error("Internal register write reached the external port.");
endmodule

// ### tb/spcr_host.sv
`timescale 1ns/1ps
// Serial host: sclk rests low between frames and every phase lasts several clocks.
module spcr_host (
   input wire logic sys_clk_i,
   input wire logic sdio_line_i,
   input wire logic sdo_line_i,
   output logic csb_n_o,
   output logic sclk_o,
   output logic sdio_o
);
   initial begin
      csb_n_o = 1'b1;
      sclk_o = 1'b0;
      sdio_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Read data is taken just before the rise, long after the device drove it.
   task automatic bit_io(input logic b, input logic four, output logic r);
      sclk_o = 1'b0;
      sdio_o = b;
      wt(6);
      r = four ? sdo_line_i : sdio_line_i;
      sclk_o = 1'b1;
      wt(5);
   endtask
   task automatic xfer(input logic rd, input logic lsb, input logic four, input logic [12:0] a, input int n,
                       inout logic [15:0] d);
      logic [15:0] ins;
      logic r;
      int k;
      ins = {rd, 2'b00, a};
      csb_n_o = 1'b0;
      wt(5);
      for (int i = 0; i < 16; i++) begin
         bit_io(ins[lsb ? i : 15 - i], four, r);
      end
      for (int j = 0; j < 8 * n; j++) begin
         k = 8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8);
         bit_io(rd ? ~d[k] : d[k], four, r);
         if (rd) begin
            d[k] = r;
         end
      end
      sclk_o = 1'b0;
      wt(6);
      csb_n_o = 1'b1;
      wt(6);
   endtask
endmodule

// ### tb/spcr_serial_port_config_regs_bench.sv
`timescale 1ns/1ps
module spcr_serial_port_config_regs_bench;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic i2c_mode = 1'b0;
   logic csb_n, sclk, sdio_h, sdio_d, sdio_oe, sdo_d, sdo_oe, ext_we, fws, lsb, rdbk, srst;
   logic [12:0] ext_addr, we_addr;
   logic [7:0] ext_wdata, we_data;
   logic [15:0] tag, d, v;
   int n_fail = 0;
   int check_count = 0;
   int n_srst = 0;
   int n_sdo_oe = 0;
   int n_sdio_oe = 0;
   int k;
   int seed = 32'hd771;
   wire logic sdio_line = sdio_oe ? sdio_d : sdio_h;
   // A released SDO line shows the inverse of its last value so a stale bit never matches.
   wire logic sdo_line = sdo_oe ? sdo_d : ~sdo_d;
   always #25 sys_clk = ~sys_clk;
   function automatic logic [7:0] act(input logic [12:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction
   function automatic logic [7:0] bfv(input logic [12:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   always @(posedge sys_clk) begin
      if (srst === 1'b1) n_srst <= n_srst + 1;
      if (sdo_oe === 1'b1) n_sdo_oe <= n_sdo_oe + 1;
      if (sdio_oe === 1'b1) n_sdio_oe <= n_sdio_oe + 1;
      if (ext_we === 1'b1) begin
         we_addr <= ext_addr;
         we_data <= ext_wdata;
      end
   end
   spcr_host spcr_host_inst (.sys_clk_i(sys_clk), .sdio_line_i(sdio_line), .sdo_line_i(sdo_line),
      .csb_n_o(csb_n), .sclk_o(sclk), .sdio_o(sdio_h));
   spcr_serial_port_config_regs spcr_serial_port_config_regs_inst (.sys_clk_i(sys_clk), .reset_i(reset),
      .spi_csb_n_i(csb_n), .spi_sclk_i(sclk), .spi_sdio_i(sdio_line), .spi_sdio_o(sdio_d),
      .spi_sdio_oe_o(sdio_oe), .spi_sdo_o(sdo_d), .spi_sdo_oe_o(sdo_oe), .i2c_mode_i(i2c_mode),
      .ext_addr_o(ext_addr), .ext_wdata_o(ext_wdata), .ext_we_o(ext_we), .ext_active_rdata_i(act(ext_addr)),
      .ext_buffer_rdata_i(bfv(ext_addr)), .four_wire_select_o(fws), .lsb_first_o(lsb),
      .readback_buffer_o(rdbk), .soft_reset_o(srst), .user_version_tag_o(tag));
   task automatic close_out;
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rd1(input logic l, input logic f, input logic [12:0] a, input logic [7:0] e, input string nm);
      d = 16'h0000;
      spcr_host_inst.xfer(1'b1, l, f, a, 1, d);
      chk(nm, {8'h00, e}, d);
   endtask
   task automatic wr(input logic l, input logic f, input logic [12:0] a, input int n, input logic [15:0] x);
      d = x;
      spcr_host_inst.xfer(1'b0, l, f, a, n, d);
   endtask
   initial begin
      #2_000_000;
      n_fail++;
      close_out();
   end
   initial begin
      repeat (20) @(negedge sys_clk);
      reset = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk("tag", 16'h0000, tag);
      rd1(1'b0, 1'b0, spcr_pkg::ADDR_VER_HI, 8'h00, "ver_hi");
      rd1(1'b0, 1'b0, spcr_pkg::ADDR_SETUP, 8'h00, "setup");
      rd1(1'b0, 1'b0, spcr_pkg::ADDR_RDBK, 8'h00, "rdbk");
      rd1(1'b0, 1'b0, 13'h0123, act(13'h0123), "active");
      // Two-byte MSB-first read: the second byte must come from the next lower address.
      d = 16'h0000;
      spcr_host_inst.xfer(1'b1, 1'b0, 1'b0, 13'h0124, 2, d);
      chk("rd_dec", {act(13'h0123), act(13'h0124)}, d);
      chk("sdo_oe", 16'h0000, 16'(n_sdo_oe));
      for (int i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         wr(1'b0, 1'b0, spcr_pkg::ADDR_VER_HI, 2, {v[7:0], v[15:8]});
         chk("tag", v, tag);
         chk("fws", 16'h0000, 16'(fws));
         rd1(1'b0, 1'b0, spcr_pkg::ADDR_VER_LO, v[7:0], "ver_lo");
      end
      wr(1'b0, 1'b0, 13'h0123, 1, v);
      chk("we_addr", 16'h0123, 16'(we_addr));
      chk("we_data", {8'h00, v[7:0]}, 16'(we_data));
      wr(1'b0, 1'b0, spcr_pkg::ADDR_RDBK, 1, 16'h0001);
      chk("rdbk", 16'h0001, 16'(rdbk));
      rd1(1'b0, 1'b0, 13'h0123, bfv(13'h0123), "buffer");
      wr(1'b0, 1'b0, spcr_pkg::ADDR_SETUP, 1, 16'h0081);
      chk("fws", 16'h0001, 16'(fws));
      k = n_sdio_oe;
      rd1(1'b0, 1'b1, spcr_pkg::ADDR_SETUP, 8'h81, "setup4");
      chk("sdio_oe", 16'(k), 16'(n_sdio_oe));
      wr(1'b0, 1'b1, spcr_pkg::ADDR_SETUP, 1, 16'h00c3);
      chk("lsb", 16'h0001, 16'(lsb));
      v = 16'($random(seed));
      wr(1'b1, 1'b1, spcr_pkg::ADDR_VER_LO, 2, v);
      chk("tag", v, tag);
      rd1(1'b1, 1'b1, spcr_pkg::ADDR_SETUP, 8'hc3, "setup_lsb");
      i2c_mode = 1'b1;
      repeat (5) @(negedge sys_clk);
      chk("i2c_sel", 16'h0000, {14'h0000, fws, lsb});
      // In I2C mode a write that clears bits 7 and 6 must leave the stored selects alone.
      wr(1'b0, 1'b0, spcr_pkg::ADDR_SETUP, 1, 16'h0000);
      rd1(1'b0, 1'b0, spcr_pkg::ADDR_SETUP, 8'h00, "setup_i2c");
      i2c_mode = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk("spi_sel", 16'h0003, {14'h0000, fws, lsb});
      k = n_srst;
      wr(1'b1, 1'b1, spcr_pkg::ADDR_SETUP, 1, 16'h0024);
      chk("srst", 16'h0001, 16'(n_srst - k));
      chk("after_srst", 16'h0000, tag | {13'h0000, fws, lsb, rdbk});
      rd1(1'b0, 1'b0, spcr_pkg::ADDR_SETUP, 8'h00, "setup_clr");
      close_out();
   end
endmodule
